// ===== design/ipd_pkg.sv
// Package for the ignition pre-driver control and diagnosis block
package ipd_pkg;
  localparam int unsigned NUM_CH          = 4;
  localparam int unsigned CLK_MHZ         = 100;
  // Filter window: 50 to 100 us; the count sits at the least value, rounded up
  localparam int unsigned FILT_MIN_US     = 50;
  localparam int unsigned FILT_MAX_US     = 100;
  localparam int unsigned FILT_CYCLES     = FILT_MIN_US * CLK_MHZ;
  localparam int unsigned FILT_W          = 16;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_CFG2        = 8'h04;
  localparam logic [7:0] ADDR_DIAG        = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT    = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR     = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN      = 8'h14;

  // Config register two field positions
  localparam int unsigned CFG2_LSOFF_BIT  = 0;
  localparam int unsigned CFG2_GSEL_BIT   = 1;
  localparam int unsigned CFG2_BLATCH_BIT = 2;
  localparam int unsigned CFG2_ODIS_BIT   = 3;

  localparam logic [3:0]  CTRL_RST        = 4'h0;
  localparam logic [3:0]  CFG2_RST        = 4'h0;
  localparam logic [3:0]  IRQ_EN_RST      = 4'h0;

  localparam logic [1:0]  AXI_OKAY        = 2'h0;
  localparam logic [1:0]  AXI_SLVERR      = 2'h2;

  // Two-bit fault codes
  typedef enum logic [1:0] {
    FC_GND  = 2'h0,
    FC_OL   = 2'h1,
    FC_BAT  = 2'h2,
    FC_OK   = 2'h3
  } ipd_fault_t;

  // Comparator inputs of one channel
  typedef struct packed {
    logic overcurrent;
    logic low_voltage;
    logic undercurrent;
    logic battery_volt;
  } ipd_cmp_t;

  // Configuration seen by every channel
  typedef struct packed {
    logic global_output_disable;
    logic battery_short_latch_select;
    logic ground_short_method_select;
    logic lowside_keep_off;
  } ipd_cfg_t;
endpackage : ipd_pkg

// ===== design/ipd_channel.sv
// One ignition channel: command gating, filters and fault state
`timescale 1ns/1ns
`default_nettype none
module ipd_channel #(
  parameter int unsigned FILT_CYCLES = ipd_pkg::FILT_CYCLES
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ctrl_bit_i,
  input  wire logic             pin_i,
  input  wire ipd_pkg::ipd_cfg_t cfg_i,
  input  wire ipd_pkg::ipd_cmp_t cmp_i,
  input  wire logic             diag_read_i,
  output logic                  drive_hi_o,
  output logic                  drive_lo_o,
  output logic                  drive_oe_o,
  output ipd_pkg::ipd_fault_t   code_o,
  output logic                  event_o
);
  localparam logic [ipd_pkg::FILT_W-1:0] FMAX = ipd_pkg::FILT_W'(FILT_CYCLES);

  logic cmd;
  logic cmd_prev_reg, cmd_prev_next;
  logic gnd_reg, gnd_next;
  logic ol_reg, ol_next;
  logic bat_reg, bat_next;
  logic [ipd_pkg::FILT_W-1:0] gcnt_reg, gcnt_next;
  logic [ipd_pkg::FILT_W-1:0] ocnt_reg, ocnt_next;
  logic [ipd_pkg::FILT_W-1:0] bcnt_reg, bcnt_next;
  logic [ipd_pkg::FILT_W-1:0] rcnt_reg, rcnt_next;
  logic g_cond;
  logic g_hit, o_hit, b_hit, r_hit;
  logic on_q;
  logic cmd_rise;
  logic evt_next;

  function automatic logic [ipd_pkg::FILT_W-1:0] filt_step(
    input logic cond, input logic [ipd_pkg::FILT_W-1:0] cnt);
    if (!cond) begin
      filt_step = '0;
    end else if (cnt < FMAX) begin
      filt_step = cnt + 1'b1;
    end else begin
      filt_step = cnt;
    end
  endfunction

  always_comb begin
    cmd      = ctrl_bit_i & pin_i;
    cmd_rise = cmd & ~cmd_prev_reg;
    on_q     = cmd & ~gnd_reg & ~bat_reg;
    // Short to ground detected by current or by voltage
    g_cond   = cfg_i.ground_short_method_select ? cmp_i.low_voltage : cmp_i.overcurrent;
    gcnt_next = filt_step(on_q & g_cond, gcnt_reg);
    ocnt_next = filt_step(on_q & cmp_i.undercurrent, ocnt_reg);
    bcnt_next = filt_step(~bat_reg & cmp_i.battery_volt, bcnt_reg);
    rcnt_next = filt_step(bat_reg & ~cmp_i.battery_volt, rcnt_reg);
    g_hit = (gcnt_reg == FMAX);
    o_hit = (ocnt_reg == FMAX);
    b_hit = (bcnt_reg == FMAX);
    r_hit = (rcnt_reg == FMAX);
    cmd_prev_next = cmd;

    gnd_next = gnd_reg;
    if (diag_read_i || cmd_rise) begin
      gnd_next = 1'b0;
    end
    if (g_hit) begin
      gnd_next = 1'b1;
    end

    ol_next = ol_reg;
    if (diag_read_i) begin
      ol_next = 1'b0;
    end
    if (o_hit) begin
      ol_next = 1'b1;
    end

    bat_next = bat_reg;
    if (cfg_i.battery_short_latch_select) begin
      if (diag_read_i || cmd_rise) begin
        bat_next = 1'b0;
      end
    end else if (r_hit) begin
      bat_next = 1'b0;
    end
    if (b_hit) begin
      bat_next = 1'b1;
    end
    evt_next = (g_hit & ~gnd_reg) | (o_hit & ~ol_reg) | (b_hit & ~bat_reg);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_prev_reg <= 1'b0;
      gnd_reg      <= 1'b0;
      ol_reg       <= 1'b0;
      bat_reg      <= 1'b0;
      gcnt_reg     <= '0;
      ocnt_reg     <= '0;
      bcnt_reg     <= '0;
      rcnt_reg     <= '0;
      drive_hi_o   <= 1'b0;
      drive_lo_o   <= 1'b0;
      drive_oe_o   <= 1'b0;
      code_o       <= ipd_pkg::FC_OK;
      event_o      <= 1'b0;
    end else begin
      cmd_prev_reg <= cmd_prev_next;
      gnd_reg      <= gnd_next;
      ol_reg       <= ol_next;
      bat_reg      <= bat_next;
      gcnt_reg     <= gcnt_next;
      ocnt_reg     <= ocnt_next;
      bcnt_reg     <= bcnt_next;
      rcnt_reg     <= rcnt_next;
      drive_hi_o   <= cmd & ~gnd_next & ~bat_next;
      drive_lo_o   <= ~cmd & ~cfg_i.lowside_keep_off;
      drive_oe_o   <= ~cfg_i.global_output_disable & ~gnd_next & ~bat_next;
      // Battery short outranks open load
      code_o       <= bat_next ? ipd_pkg::FC_BAT :
                      gnd_next ? ipd_pkg::FC_GND :
                      ol_next  ? ipd_pkg::FC_OL  : ipd_pkg::FC_OK;
      event_o      <= evt_next;
    end
  end
endmodule // ipd_channel
`default_nettype wire

// ===== design/ipd_top.sv
// Ignition pre-driver control and diagnosis with AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
module ipd_top #(
  parameter int unsigned NUM_CH      = ipd_pkg::NUM_CH,
  parameter int unsigned FILT_CYCLES = ipd_pkg::FILT_CYCLES
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [NUM_CH-1:0]    ign_pin_i,
  input  wire ipd_pkg::ipd_cmp_t [NUM_CH-1:0] cmp_i,
  output logic [NUM_CH-1:0]         ignition_output_hi_o,
  output logic [NUM_CH-1:0]         ignition_output_lo_o,
  output logic [NUM_CH-1:0]         ignition_output_oe_o,
  output logic                      irq_o
);
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_RESP = 3'b010,
    WR_WAIT = 3'b100
  } ipd_wst_t;

  logic [NUM_CH-1:0] ctrl_reg, ctrl_next;
  logic [3:0]        cfg2_reg, cfg2_next;
  logic [NUM_CH-1:0] irq_stat_reg, irq_stat_next;
  logic [NUM_CH-1:0] irq_en_reg, irq_en_next;
  logic              irq_next;
  ipd_wst_t          wst_reg, wst_next;
  logic              aw_got_reg, aw_got_next;
  logic              w_got_reg, w_got_next;
  logic [7:0]        awaddr_reg, awaddr_next;
  logic [31:0]       wdata_reg, wdata_next;
  logic [3:0]        wstrb_reg, wstrb_next;
  logic [1:0]        bresp_next;
  logic              bvalid_next;
  logic              rvalid_next;
  logic [31:0]       rdata_next;
  logic [1:0]        rresp_next;
  logic              diag_read;
  ipd_pkg::ipd_cfg_t cfg;
  ipd_pkg::ipd_fault_t [NUM_CH-1:0] code;
  logic [NUM_CH-1:0] chan_evt;
  logic [NUM_CH-1:0] hi_w, lo_w, oe_w;

  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge_bytes[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  always_comb begin
    cfg.lowside_keep_off           = cfg2_reg[ipd_pkg::CFG2_LSOFF_BIT];
    cfg.ground_short_method_select = cfg2_reg[ipd_pkg::CFG2_GSEL_BIT];
    cfg.battery_short_latch_select = cfg2_reg[ipd_pkg::CFG2_BLATCH_BIT];
    cfg.global_output_disable      = cfg2_reg[ipd_pkg::CFG2_ODIS_BIT];
  end

  // Write channel: address and data taken in either order
  always_comb begin
    wst_next    = wst_reg;
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next  = wdata_reg;
    wstrb_next  = wstrb_reg;
    bresp_next  = s_axi_bresp;
    bvalid_next = s_axi_bvalid;
    ctrl_next   = ctrl_reg;
    cfg2_next   = cfg2_reg;
    irq_en_next = irq_en_reg;
    irq_stat_next = irq_stat_reg | chan_evt;
    unique case (wst_reg)
      WR_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_got_next = 1'b1;
          awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_got_next = 1'b1;
          wdata_next = s_axi_wdata;
          wstrb_next = s_axi_wstrb;
        end
        if (aw_got_reg && w_got_reg) begin
          wst_next = WR_RESP;
        end
      end
      WR_RESP: begin
        bresp_next = ipd_pkg::AXI_OKAY;
        unique case (awaddr_reg)
          ipd_pkg::ADDR_CTRL:
            ctrl_next = NUM_CH'(merge_bytes(32'(ctrl_reg), wdata_reg, wstrb_reg));
          ipd_pkg::ADDR_CFG2:
            cfg2_next = 4'(merge_bytes(32'(cfg2_reg), wdata_reg, wstrb_reg));
          ipd_pkg::ADDR_IRQ_EN:
            irq_en_next = NUM_CH'(merge_bytes(32'(irq_en_reg), wdata_reg, wstrb_reg));
          ipd_pkg::ADDR_IRQ_CLR: begin
            if (wstrb_reg[0]) begin
              irq_stat_next = (irq_stat_reg & ~wdata_reg[NUM_CH-1:0]) | chan_evt;
            end
          end
          ipd_pkg::ADDR_DIAG, ipd_pkg::ADDR_IRQ_STAT: ;
          default: bresp_next = ipd_pkg::AXI_SLVERR;
        endcase
        bvalid_next = 1'b1;
        aw_got_next = 1'b0;
        w_got_next  = 1'b0;
        wst_next    = WR_WAIT;
      end
      WR_WAIT: begin
        if (s_axi_bready) begin
          bvalid_next = 1'b0;
          wst_next    = WR_IDLE;
        end
      end
      default: wst_next = WR_IDLE;
    endcase
    irq_next = |(irq_stat_next & irq_en_next);
  end

  // Read channel: one cycle answer, diagnosis read clears latched faults
  always_comb begin
    diag_read   = 1'b0;
    rvalid_next = s_axi_rvalid;
    rdata_next  = s_axi_rdata;
    rresp_next  = s_axi_rresp;
    if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        rvalid_next = 1'b0;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = ipd_pkg::AXI_OKAY;
      rdata_next  = '0;
      unique case (s_axi_araddr)
        ipd_pkg::ADDR_CTRL:     rdata_next = 32'(ctrl_reg);
        ipd_pkg::ADDR_CFG2:     rdata_next = 32'(cfg2_reg);
        ipd_pkg::ADDR_DIAG: begin
          rdata_next = 32'(code);
          diag_read  = 1'b1;
        end
        ipd_pkg::ADDR_IRQ_STAT: rdata_next = 32'(irq_stat_reg);
        ipd_pkg::ADDR_IRQ_EN:   rdata_next = 32'(irq_en_reg);
        ipd_pkg::ADDR_IRQ_CLR:  rdata_next = '0;
        default:                rresp_next = ipd_pkg::AXI_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wst_reg       <= WR_IDLE;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      ctrl_reg      <= ipd_pkg::CTRL_RST[NUM_CH-1:0];
      cfg2_reg      <= ipd_pkg::CFG2_RST;
      irq_en_reg    <= ipd_pkg::IRQ_EN_RST[NUM_CH-1:0];
      irq_stat_reg  <= '0;
      irq_o         <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ipd_pkg::AXI_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= ipd_pkg::AXI_OKAY;
      ignition_output_hi_o <= '0;
      ignition_output_lo_o <= '0;
      ignition_output_oe_o <= '0;
    end else begin
      wst_reg       <= wst_next;
      aw_got_reg    <= aw_got_next;
      w_got_reg     <= w_got_next;
      awaddr_reg    <= awaddr_next;
      wdata_reg     <= wdata_next;
      wstrb_reg     <= wstrb_next;
      ctrl_reg      <= ctrl_next;
      cfg2_reg      <= cfg2_next;
      irq_en_reg    <= irq_en_next;
      irq_stat_reg  <= irq_stat_next;
      irq_o         <= irq_next;
      s_axi_awready <= (wst_next == WR_IDLE) && !aw_got_next && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= (wst_next == WR_IDLE) && !w_got_next && !(s_axi_wvalid && s_axi_wready);
      s_axi_bvalid  <= bvalid_next;
      s_axi_bresp   <= bresp_next;
      s_axi_arready <= !rvalid_next && !(s_axi_arvalid && s_axi_arready);
      s_axi_rvalid  <= rvalid_next;
      s_axi_rdata   <= rdata_next;
      s_axi_rresp   <= rresp_next;
      ignition_output_hi_o <= hi_w;
      ignition_output_lo_o <= lo_w;
      ignition_output_oe_o <= oe_w;
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    ipd_channel #(
      .FILT_CYCLES (FILT_CYCLES)
    ) u_ch (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .ctrl_bit_i  (ctrl_reg[c]),
      .pin_i       (ign_pin_i[c]),
      .cfg_i       (cfg),
      .cmp_i       (cmp_i[c]),
      .diag_read_i (diag_read),
      .drive_hi_o  (hi_w[c]),
      .drive_lo_o  (lo_w[c]),
      .drive_oe_o  (oe_w[c]),
      .code_o      (code[c]),
      .event_o     (chan_evt[c])
    );
  end
endmodule // ipd_top
`default_nettype wire

// ===== sim/ipd_top_monitor.sv
// Concurrent checks on the ports of the ignition pre-driver top
`timescale 1ns/1ns
`default_nettype none
module ipd_top_monitor #(
  parameter int unsigned NUM_CH      = ipd_pkg::NUM_CH,
  parameter int unsigned FILT_CYCLES = ipd_pkg::FILT_CYCLES
) (
  input wire logic                           clk_i,
  input wire logic                           rst_n_i,
  input wire logic                           s_axi_arvalid,
  input wire logic                           s_axi_arready,
  input wire logic                           s_axi_rvalid,
  input wire logic                           s_axi_rready,
  input wire logic [NUM_CH-1:0]              ign_pin_i,
  input wire ipd_pkg::ipd_cmp_t [NUM_CH-1:0] cmp_i,
  input wire logic [NUM_CH-1:0]              ignition_output_hi_o,
  input wire logic [NUM_CH-1:0]              ignition_output_lo_o,
  input wire logic [NUM_CH-1:0]              ignition_output_oe_o,
  input wire logic                           irq_o
);
  logic [NUM_CH-1:0] uc_only;
  logic [NUM_CH-1:0] bat_long;
  logic [NUM_CH-1:0] bat_seen;
  logic [15:0]       bat_cnt [NUM_CH];
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      uc_only[c]  = cmp_i[c].undercurrent & ~(cmp_i[c].overcurrent | cmp_i[c].low_voltage | cmp_i[c].battery_volt);
      bat_seen[c] = cmp_i[c].battery_volt;
      bat_long[c] = bat_cnt[c] >= 16'(FILT_CYCLES + 3);
    end
  end
  // Run length of the battery comparator while the output stays driven; a read may release it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < NUM_CH; c++) bat_cnt[c] <= 16'h0000;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (!bat_seen[c] || !ignition_output_oe_o[c]) bat_cnt[c] <= 16'h0000;
        else if (!bat_long[c]) bat_cnt[c] <= bat_cnt[c] + 16'h0001;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_reset_hiz: assert property ($rose(rst_n_i) |-> ignition_output_oe_o == '0)
    else $error("outputs driven in the first cycle after reset");
  chk_hi_needs_pin: assert property ((ignition_output_hi_o & ~$past(ign_pin_i, 2)) == '0)
    else $error("high side on without its command pin");
  chk_no_overlap: assert property ((ignition_output_hi_o & ignition_output_lo_o) == '0)
    else $error("high and low side on together");
  chk_bat_tristate: assert property ((ignition_output_oe_o & bat_long) == '0)
    else $error("output driven under a lasting battery short");
  chk_open_driven: assert property (($past(ignition_output_oe_o) & ~ignition_output_oe_o & $past(uc_only)) == '0)
    else $error("open load released the output");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_addr_drop: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted while one is open");
  cov_fault_hiz: cover property (($past(ignition_output_oe_o) & ~ignition_output_oe_o) != '0);
  cov_irq: cover property ($rose(irq_o));
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
  cov_bat: cover property ((bat_seen & ~ignition_output_oe_o) != '0);
endmodule // ipd_top_monitor
bind ipd_top ipd_top_monitor #(.NUM_CH(NUM_CH), .FILT_CYCLES(FILT_CYCLES)) u_mon (
  .clk_i, .rst_n_i, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .ign_pin_i, .cmp_i,
  .ignition_output_hi_o, .ignition_output_lo_o, .ignition_output_oe_o, .irq_o
);
`default_nettype wire

// ===== sim/ipd_coil_model.sv
// Behavioural IGBT and coil load producing the comparator levels
`timescale 1ns/1ns
`default_nettype none
module ipd_coil_model #(
  parameter int unsigned NUM_CH = ipd_pkg::NUM_CH
) (
  input  wire logic [NUM_CH-1:0]          hi_i,
  input  wire logic [NUM_CH-1:0]          oe_i,
  input  wire logic [NUM_CH-1:0][3:0]     flt_i,
  output var ipd_pkg::ipd_cmp_t [NUM_CH-1:0] cmp_o
);
  // Fault bits: 0 hard ground short, 1 soft ground short, 2 open coil, 3 battery short
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      cmp_o[c].overcurrent  = flt_i[c][0] & hi_i[c] & oe_i[c];
      cmp_o[c].low_voltage  = flt_i[c][1] & hi_i[c] & oe_i[c];
      cmp_o[c].undercurrent = flt_i[c][2] & hi_i[c] & oe_i[c];
      cmp_o[c].battery_volt = flt_i[c][3];
    end
  end
endmodule // ipd_coil_model
`default_nettype wire

// ===== sim/test_ipd_top.sv
// Self-checking bench for the ignition pre-driver top
`timescale 1ns/1ns
`default_nettype none
module test_ipd_top;
  localparam int unsigned FILT = 8;
  // Case fields: gnd, hiz, code[1:0], latch, method, fault[3:0]
  localparam logic [9:0] TC [7] = '{10'h301, 10'h312, 10'h0C2, 10'h044, 10'h1A8, 10'h1AC, 10'h188};
  logic                    clk_i, rst_n_i, irq;
  logic                    awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]              awaddr, araddr;
  logic [31:0]             wdata, rdata;
  logic [3:0]              wstrb, pin, hi, lo, oe;
  logic [1:0]              bresp, rresp;
  logic [3:0][3:0]         flt;
  ipd_pkg::ipd_cmp_t [3:0] cmp;
  int                      num_errors, checked;
  int                      exp_code [4];
  ipd_top #(.NUM_CH(4), .FILT_CYCLES(FILT)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ign_pin_i(pin), .cmp_i(cmp), .ignition_output_hi_o(hi), .ignition_output_lo_o(lo),
    .ignition_output_oe_o(oe), .irq_o(irq)
  );
  ipd_coil_model #(.NUM_CH(4)) u_coil (.hi_i(hi), .oe_i(oe), .flt_i(flt), .cmp_o(cmp));
  task automatic summarize();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_pins(input logic [3:0] got, input logic [3:0] exp);
    cmp_word({28'h0, got}, {28'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    cmp_word({30'h0, bresp}, {30'h0, ipd_pkg::AXI_OKAY});
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  function automatic logic [31:0] exp_diag();
    logic [31:0] w;
    w = 32'h0;
    for (int c = 0; c < 4; c++) w[2*c +: 2] = exp_code[c][1:0];
    return w;
  endfunction
  task automatic diag_chk();
    logic [31:0] d;
    logic [1:0]  r;
    rd(ipd_pkg::ADDR_DIAG, d, r);
    cmp_word({24'h0, d[7:0]}, exp_diag());
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    summarize();
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [9:0]  t;
    logic [3:0]  en;
    int          ch;
    rst_n_i = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    pin = 4'h0;
    flt = '0;
    num_errors = 0;
    checked = 0;
    foreach (exp_code[c]) exp_code[c] = 3;
    d = $urandom(32'hB0FA668E);
    repeat (5) @(posedge clk_i);
    cmp_pins(oe, 4'h0);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    foreach (TC[i]) if (i < 5) begin
      rd(8'h00 + 8'(i * 4 + (i > 1 ? 4 : 0)), d, r);
      cmp_word(d, 32'h0);
      cmp_word({30'h0, r}, {30'h0, ipd_pkg::AXI_OKAY});
    end
    diag_chk();
    rd(8'h20, d, r);
    cmp_word({30'h0, r}, {30'h0, ipd_pkg::AXI_SLVERR});
    $display("test reset and map done");
    for (int i = 0; i < 12; i++) begin
      d = $urandom;
      pin <= d[7:4];
      wr(ipd_pkg::ADDR_CTRL, {28'h0, d[3:0]});
      repeat (2) @(posedge clk_i);
      cmp_pins(hi, d[3:0] & d[7:4]);
      cmp_pins(lo, ~(d[3:0] & d[7:4]));
      cmp_pins(oe, 4'hF);
    end
    pin <= 4'h0;
    wr(ipd_pkg::ADDR_CFG2, 32'h1 << ipd_pkg::CFG2_LSOFF_BIT);
    repeat (2) @(posedge clk_i);
    cmp_pins(lo | hi, 4'h0);
    wr(ipd_pkg::ADDR_CFG2, 32'h1 << ipd_pkg::CFG2_ODIS_BIT);
    repeat (2) @(posedge clk_i);
    cmp_pins(oe, 4'h0);
    $display("test command gating done");
    for (int k = 0; k < 7; k++) begin
      t = TC[k];
      ch = $urandom_range(3);
      en = (k % 2) ? 4'hF : ~(4'h1 << ch);
      pin <= 4'hF;
      wr(ipd_pkg::ADDR_CTRL, 32'hF);
      wr(ipd_pkg::ADDR_CFG2, {29'h0, t[5], t[4], 1'b0});
      wr(ipd_pkg::ADDR_IRQ_EN, {28'h0, en});
      flt[ch] <= t[3:0];
      repeat (FILT - 1) @(posedge clk_i);
      cmp_pins(oe, 4'hF);
      repeat (8) @(posedge clk_i);
      exp_code[ch] = t[7:6];
      cmp_pins(oe, ~({3'h0, t[8]} << ch));
      cmp_pins({3'h0, irq}, {3'h0, (t[7:6] != 2'h3) && en[ch]});
      if (t[9]) begin
        diag_chk();
        exp_code[ch] = 3;
        repeat (4) @(posedge clk_i);
        cmp_pins(oe, 4'hF);
        flt[ch] <= 4'h0;
      end else begin
        flt[ch] <= 4'h0;
        repeat (FILT + 6) @(posedge clk_i);
        if (!t[5] && t[3]) exp_code[ch] = 3;
        cmp_pins(oe, ~({3'h0, t[5]} << ch));
        diag_chk();
        exp_code[ch] = 3;
      end
      diag_chk();
      cmp_pins(oe, 4'hF);
      rd(ipd_pkg::ADDR_IRQ_STAT, d, r);
      cmp_word(d, {31'h0, t[7:6] != 2'h3} << ch);
      wr(ipd_pkg::ADDR_IRQ_CLR, 32'hF);
      rd(ipd_pkg::ADDR_IRQ_STAT, d, r);
      cmp_word(d, 32'h0);
      cmp_pins({3'h0, irq}, 4'h0);
      $display("test fault case %0d done", k);
    end
    summarize();
  end
endmodule // test_ipd_top
`default_nettype wire
